// *** nvmac_array.v ***
// storage array model of 128 bytes with synchronous read and write
module nvmac_array #(
	parameter AW = 7
) (
	input wire clk,
	input wire we,
	input wire [AW-1:0] addr,
	input wire [7:0] wdata,
	output reg [7:0] rdata
);
	reg [7:0] mem [0:(1<<AW)-1];

	always @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule

// *** nvmac_ctrl.v ***
// register front end and write timer for the nonvolatile byte store
//
// How it works
// RULE1: a write strobe stalls the cpu for two cycles.
// RULE2: a read strobe stalls the cpu for four cycles.
// RULE3: seven-bit address selects one of 128 bytes, 0 through 127.
// RULE4: address bit 7 and control bits 7..3 read as zero.
// RULE5: data register is write source and receives read bytes.
// RULE6: write strobe ignored unless arm bit already set.
// RULE7: arm bit clears itself four cycles after being set.
// RULE8: arm bit accepted only when the same write clears the write strobe.
// RULE9: software waits idle, arms, then strobes within four cycles.
// RULE10: write strobe stays high for the write period then clears.
// RULE11: read strobe fetches the byte then clears itself.
// RULE12: address or data write during a write aborts it.
// RULE13: software checks write strobe is zero before reading.
// RULE14: software keeps interrupts off across the arming steps.
// RULE15: internal counter times the write; strobes ignored meanwhile.
//
// the write period is one fixed count at the short end of the range; a slower
// cell needs WRITE_CYCLES raised to the long end.
`include "nvmac_defines.vh"
module nvmac_ctrl #(
	parameter WRITE_CYCLES = `NVMAC_WRITE_CYCLES,
	parameter AW = 7
) (
	input wire clk,
	input wire rst,
	input wire [5:0] io_addr,
	input wire io_wr,
	input wire io_rd,
	input wire [7:0] io_wdata,
	output reg [7:0] io_rdata,
	output reg cpu_stall,
	output reg write_busy
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	localparam ST_IDLE = 2'd0;
	localparam ST_READ = 2'd1;
	localparam ST_WRITE = 2'd2;

	reg [1:0] state;
	reg [AW-1:0] nvm_byte_address;
	reg [7:0] nvm_byte_data;
	reg write_arm_bit;
	reg write_strobe_bit;
	reg read_strobe_bit;
	reg [2:0] arm_cnt;
	reg [2:0] stall_cnt;
	reg [31:0] wr_cnt;
	reg [1:0] rd_phase;
	reg arr_we;
	wire [7:0] arr_rdata;

	// ----------------------------------------
	// decoding helpers
	// ----------------------------------------
	// one compare per register, shared by the write decode and the read mux
	function reg_hit;
		input [5:0] a;
		input [5:0] ofs;
		begin
			reg_hit = (a == ofs);
		end
	endfunction

	// control image; reserved bits 7..3 are tied low here and nowhere else
	function [7:0] ctrl_image;
		input arm;
		input wr;
		input rd;
		begin
			ctrl_image = {5'h00, arm, wr, rd}; // RULE4
		end
	endfunction

	wire wr_addr = io_wr && reg_hit(io_addr, `NVMAC_ADDR_OFS);
	wire wr_data = io_wr && reg_hit(io_addr, `NVMAC_DATA_OFS);
	wire wr_ctrl = io_wr && reg_hit(io_addr, `NVMAC_CTRL_OFS);
	wire ctrl_arm = io_wdata[`NVMAC_ARM_BIT];
	wire ctrl_write = io_wdata[`NVMAC_WRITE_BIT];
	wire ctrl_read = io_wdata[`NVMAC_READ_BIT];
	wire busy = (state != ST_IDLE);
	// write only starts from an already armed bit and an idle block
	wire start_write = wr_ctrl && ctrl_write && write_arm_bit && !busy; // RULE6 RULE15
	// a control write that also sets the write bit is taken as a write attempt only
	wire start_read = wr_ctrl && ctrl_read && !ctrl_write && !busy;

	nvmac_array #(
		.AW(AW)
	) u_array (
		.clk(clk),
		.we(arr_we),
		.addr(nvm_byte_address),
		.wdata(nvm_byte_data),
		.rdata(arr_rdata)
	);

	// ----------------------------------------
	// register, arming and access sequencing
	// ----------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			nvm_byte_address <= `NVMAC_ADDR_RESET;
			nvm_byte_data <= `NVMAC_DATA_RESET;
			write_strobe_bit <= 1'b0;
			read_strobe_bit <= 1'b0;
			wr_cnt <= 32'd0;
			rd_phase <= 2'd0;
			arr_we <= 1'b0;
		end else begin
			arr_we <= 1'b0;
			if (wr_addr) begin
				nvm_byte_address <= io_wdata[AW-1:0]; // RULE3
			end
			if (wr_data) begin
				nvm_byte_data <= io_wdata; // RULE5
			end
			case (state)
			ST_IDLE: begin
				if (start_write) begin
					state <= ST_WRITE;
					write_strobe_bit <= 1'b1; // RULE10
					wr_cnt <= WRITE_CYCLES - 1;
				end else if (start_read) begin
					state <= ST_READ;
					read_strobe_bit <= 1'b1;
					rd_phase <= 2'd0;
				end
			end
			ST_READ: begin
				// array has one cycle latency, byte caught on the second
				rd_phase <= rd_phase + 2'd1;
				if (rd_phase == 2'd1) begin
					nvm_byte_data <= arr_rdata; // RULE5 RULE11
					read_strobe_bit <= 1'b0; // RULE11
					state <= ST_IDLE;
				end
			end
			ST_WRITE: begin
				if (wr_addr || wr_data) begin
					// interrupted write leaves the cell undefined; we skip it
					state <= ST_IDLE; // RULE12
					write_strobe_bit <= 1'b0;
				end else if (wr_cnt == 32'd0) begin
					// the cell is written once, at the end, so an abort leaves it untouched
					arr_we <= 1'b1; // RULE10
					write_strobe_bit <= 1'b0;
					state <= ST_IDLE;
				end else begin
					wr_cnt <= wr_cnt - 32'd1; // RULE15
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------
	// write arming window
	// ----------------------------------------
	// the arm is a short key: it lapses on its own so a stray strobe long
	// after arming cannot start a write, and the strobe it enables spends it
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			write_arm_bit <= 1'b0;
			arm_cnt <= 3'h0;
		end else if (start_write) begin
			write_arm_bit <= 1'b0;
			arm_cnt <= 3'h0;
		end else if (wr_ctrl && ctrl_arm && !ctrl_write) begin
			write_arm_bit <= 1'b1; // RULE8
			arm_cnt <= `NVMAC_ARM_CYCLES;
		end else if (arm_cnt != 3'h0) begin
			arm_cnt <= arm_cnt - 3'h1;
			if (arm_cnt == 3'h1) begin
				write_arm_bit <= 1'b0; // RULE7
			end
		end
	end

	// ----------------------------------------
	// cpu stall timing
	// ----------------------------------------
	// the stall is counted from the accepted strobe, not from the state, so a
	// read that finishes early still holds the cpu for its full four cycles
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			stall_cnt <= 3'h0;
		end else if (start_write) begin
			stall_cnt <= `NVMAC_WSTALL_CYCLES; // RULE1
		end else if (start_read) begin
			stall_cnt <= `NVMAC_RSTALL_CYCLES; // RULE2
		end else if (stall_cnt != 3'h0) begin
			stall_cnt <= stall_cnt - 3'h1;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cpu_stall <= 1'b0;
			write_busy <= 1'b0;
			io_rdata <= 8'h00;
		end else begin
			cpu_stall <= start_write || start_read || (stall_cnt > 3'd1); // RULE1 RULE2
			write_busy <= write_strobe_bit;
			// unmapped offsets read as zero rather than holding the last register
			if (reg_hit(io_addr, `NVMAC_ADDR_OFS)) begin
				io_rdata <= {1'b0, nvm_byte_address}; // RULE4
			end else if (reg_hit(io_addr, `NVMAC_DATA_OFS)) begin
				io_rdata <= nvm_byte_data;
			end else if (reg_hit(io_addr, `NVMAC_CTRL_OFS)) begin
				io_rdata <= ctrl_image(write_arm_bit, write_strobe_bit, read_strobe_bit);
			end else begin
				io_rdata <= 8'h00;
			end
		end
	end
endmodule

// *** nvmac_ctrl_sva.sv ***
// assertions on the ports of the nonvolatile byte access controller
module nvmac_sva #(parameter WRITE_CYCLES = 20) (
	input wire clk,
	input wire rst,
	input wire [5:0] io_addr,
	input wire io_wr,
	input wire [7:0] io_wdata,
	input wire [7:0] io_rdata,
	input wire cpu_stall,
	input wire write_busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire ctl = io_wr && io_addr == 6'h1c;
	// length of the current busy spell, and whether an address or data write cut it
	logic [31:0] busy_len;
	logic cut;
	always @(posedge clk) begin
		if (rst || !write_busy) begin
			busy_len <= 32'h0;
			cut <= 1'b0;
		end else begin
			busy_len <= busy_len + 32'h1;
			if (io_wr && (io_addr == 6'h1e || io_addr == 6'h1d)) cut <= 1'b1;
		end
	end
	AST_STALL_MAX: assert property (cpu_stall [*4] |=> !cpu_stall)
		else $error("stall held too long");
	AST_READ_STALL: assert property (ctl && io_wdata == 8'h01 && !cpu_stall && !write_busy
		|=> cpu_stall [*4] ##1 !cpu_stall) else $error("read stall not four cycles");
	AST_WRITE_STALL: assert property ($rose(write_busy)
		|-> cpu_stall && $past(cpu_stall) && !$past(cpu_stall, 2) ##1 !cpu_stall)
		else $error("write stall not two cycles");
	AST_BUSY_LEN: assert property ($fell(write_busy) |-> cut || busy_len == WRITE_CYCLES)
		else $error("write period length wrong");
	AST_ADDR_TOP: assert property (io_addr == 6'h1e |=> !io_rdata[7])
		else $error("address top bit not zero");
	AST_CTRL_TOP: assert property (io_addr == 6'h1c |=> io_rdata[7:3] == 5'h00)
		else $error("control upper bits not zero");
	AST_STALL_CAUSE: assert property ($rose(cpu_stall) |-> $past(ctl))
		else $error("stall without control write");
	AST_BUSY_IGNORE: assert property (ctl && write_busy ##1 write_busy |-> !cpu_stall)
		else $error("strobe taken while busy");
	cover property (ctl && io_wdata == 8'h01 && !write_busy);
	cover property ($rose(write_busy));
	cover property (ctl && write_busy);
	cover property ($fell(write_busy) && cut);
endmodule
bind nvmac_ctrl nvmac_sva #(.WRITE_CYCLES(WRITE_CYCLES)) i_sva (.clk(clk), .rst(rst),
	.io_addr(io_addr), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
	.cpu_stall(cpu_stall), .write_busy(write_busy));

// *** nvmac_ctrl_test.sv ***
// self-checking bench for the nonvolatile byte access controller
module nvmac_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, io_wr = 0, s_we = 0;
	logic [5:0] io_addr = 6'h00;
	logic [7:0] io_wdata = 8'h00;
	wire [7:0] io_rdata, s_q;
	wire cpu_stall, write_busy;
	int n_fail = 0, checked = 0;
	logic [21:0] rows [4] = '{{6'h1e, 8'hff, 8'h7f}, {6'h1e, 8'h2a, 8'h2a},
		{6'h1d, 8'ha5, 8'ha5}, {6'h1c, 8'hf8, 8'h00}};
	always #2.5 clk = ~clk;
	nvmac_ctrl #(.WRITE_CYCLES(20)) i_dut (.clk(clk), .rst(rst), .io_addr(io_addr),
		.io_wr(io_wr), .io_rd(1'b0), .io_wdata(io_wdata), .io_rdata(io_rdata),
		.cpu_stall(cpu_stall), .write_busy(write_busy));
	nvmac_store_model i_store (.clk(clk), .we(s_we), .addr(7'h7f), .wdata(8'h3c), .rdata(s_q));
	task automatic summarize;
		if (n_fail == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	// the cpu may not issue while stalled, so every access waits here first
	task automatic go;
		#1;
		while (cpu_stall !== 1'b0) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
	endtask
	task automatic wr(logic [5:0] a, logic [7:0] d);
		go;
		io_wr <= 1'b1;
		io_addr <= a;
		io_wdata <= d;
		@(posedge clk);
		io_wr <= 1'b0;
	endtask
	task automatic rd(logic [5:0] a, logic [7:0] e);
		go;
		io_addr <= a;
		@(posedge clk);
		#1;
		chk("io_rdata", e, io_rdata);
	endtask
	initial begin
		#20000;
		n_fail++;
		summarize;
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd(6'h1e, 8'h00);
		chk("flags", 8'h00, {6'h00, cpu_stall, write_busy});
		foreach (rows[i]) begin
			wr(rows[i][21:16], rows[i][15:8]);
			rd(rows[i][21:16], rows[i][7:0]);
		end
		wr(6'h1e, 8'h7f);
		wr(6'h1d, 8'h3c);
		wr(6'h1c, 8'h04);
		wr(6'h1c, 8'h02);
		s_we <= 1'b1;
		@(posedge clk);
		s_we <= 1'b0;
		rd(6'h1c, 8'h02);
		wr(6'h1c, 8'h01);
		rd(6'h1c, 8'h02);
		for (int i = 0; i < 40 && write_busy !== 1'b0; i++) @(posedge clk);
		rd(6'h1c, 8'h00);
		wr(6'h1d, 8'h55);
		wr(6'h1c, 8'h02);
		wr(6'h1c, 8'h06);
		wr(6'h1c, 8'h02);
		rd(6'h1c, 8'h00);
		wr(6'h1c, 8'h04);
		rd(6'h1c, 8'h04);
		repeat (4) @(posedge clk);
		wr(6'h1c, 8'h02);
		rd(6'h1c, 8'h00);
		wr(6'h1c, 8'h01);
		rd(6'h1c, 8'h00);
		rd(6'h1d, s_q);
		wr(6'h1c, 8'h04);
		wr(6'h1c, 8'h02);
		wr(6'h1d, 8'h99);
		rd(6'h1c, 8'h00);
		summarize;
	end
endmodule

// *** nvmac_defines.vh ***
// constants for the nonvolatile byte access controller
`ifndef NVMAC_DEFINES_VH
`define NVMAC_DEFINES_VH
// ----------------------------------------
// register offsets (i/o space)
// ----------------------------------------
`define NVMAC_ADDR_OFS 6'h1e
`define NVMAC_DATA_OFS 6'h1d
`define NVMAC_CTRL_OFS 6'h1c
// ----------------------------------------
// control register fields and address/data register reset values
// ----------------------------------------
`define NVMAC_READ_BIT 0
`define NVMAC_WRITE_BIT 1
`define NVMAC_ARM_BIT 2
`define NVMAC_ADDR_RESET 7'h00
`define NVMAC_DATA_RESET 8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define NVMAC_CLK_MHZ 200
`define NVMAC_WRITE_US 2500
`define NVMAC_WRITE_CYCLES (`NVMAC_WRITE_US * `NVMAC_CLK_MHZ)
`define NVMAC_ARM_CYCLES 3'h4
`define NVMAC_WSTALL_CYCLES 3'h2
`define NVMAC_RSTALL_CYCLES 3'h4
`endif

// *** nvmac_store_model.sv ***
// stand-in for the byte store that holds what the bench expects to read back
module nvmac_store_model (
	input wire logic clk,
	input wire logic we,
	input wire logic [6:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [128];
	// unwritten cells read as all ones, so a missed store cannot pass
	initial foreach (mem[i]) mem[i] = 8'hff;
	always @(posedge clk) if (we) mem[addr] <= wdata;
	assign rdata = mem[addr];
endmodule
